// ---- rtl/fsr_pkg.sv ----
// Shared constants for the flux sensor serial readout block
package fsr_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned T_HOLD1_NS = 10;
  localparam int unsigned T_TRACK2_US = 32;
  localparam int unsigned T_HOLD2_US = 96;
  localparam int unsigned HOLD1_CYC_RAW = (T_HOLD1_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD1_CYC = (HOLD1_CYC_RAW < 1) ? 1 : HOLD1_CYC_RAW;
  localparam int unsigned TRACK2_CYC = T_TRACK2_US * CLK_MHZ;
  localparam int unsigned HOLD2_CYC = T_HOLD2_US * CLK_MHZ;
  localparam int unsigned ACQ_CNT_W = 16;

  localparam int unsigned RESULT_W = 12;
  localparam int unsigned FILT_W = 3;
  localparam int unsigned GAIN_W = 6;
  localparam int unsigned FRAC_W = 7;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BIT_CNT_W = 5;
  localparam logic [1:0] WR_PREFIX = 2'h2;
  localparam int unsigned PFX_HI = 15;
  localparam int unsigned PFX_LO = 14;
  localparam int unsigned FILT_HI = 13;
  localparam int unsigned FILT_LO = 11;
  localparam int unsigned GAIN_HI = 10;
  localparam int unsigned GAIN_LO = 5;
  localparam int unsigned BURN_BIT = 0;
  localparam logic [11:0] MID_SCALE = 12'h800;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  // Gain = (GAIN_BASE + 2*code)/256: 0.75 .. 1.24 in 0.78 percent steps
  localparam logic [8:0] GAIN_BASE = 9'h0C0;
  localparam int unsigned GAIN_SHIFT = 8;

  typedef enum logic [1:0] {FSR_ACQ_TRACK1, FSR_ACQ_HOLD1, FSR_ACQ_TRACK2, FSR_ACQ_CONV} fsr_acq_e;
endpackage

// ---- rtl/fsr_filter.sv ----
// Gain trim and moving-average filter on each conversion result
`timescale 1ns/1ps
`default_nettype none
module fsr_filter
  import fsr_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [RESULT_W-1:0] sample_in,
  input wire logic [FILT_W-1:0] filt_sel_in,
  input wire logic [GAIN_W-1:0] gain_trim_in,
  output logic [RESULT_W-1:0] result_out
);
  localparam int unsigned ACC_W = RESULT_W + FRAC_W + 2;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;
  logic signed [12:0] diff;
  logic signed [9:0] gain;
  logic signed [23:0] prod;
  logic signed [15:0] scaled;
  logic [RESULT_W-1:0] trimmed;
  logic signed [ACC_W-1:0] target;
  logic signed [ACC_W-1:0] delta;
  logic signed [ACC_W-1:0] step;

  always_comb begin
    // Scale about midscale so zero field stays at 2048
    diff = $signed({1'b0, sample_in}) - $signed({1'b0, MID_SCALE});
    gain = $signed({1'b0, GAIN_BASE + {2'h0, gain_trim_in, 1'b0}});
    prod = diff * gain;
    scaled = 16'(prod >>> GAIN_SHIFT) + 16'(MID_SCALE);
    if (scaled < 0) begin
      trimmed = '0;
    end else if (scaled > $signed({4'h0, FULL_SCALE})) begin
      trimmed = FULL_SCALE;
    end else begin
      trimmed = scaled[RESULT_W-1:0];
    end
    target = $signed({2'h0, trimmed, {FRAC_W{1'b0}}});
    delta = target - acc;
    step = delta >>> filt_sel_in;
    // Nudge a vanishing step so a steady input settles exactly
    if (step == 0 && delta != 0) begin
      step = (delta < 0) ? '1 : ACC_W'(1);
    end
    next_acc = acc;
    if (sample_valid_in) begin
      next_acc = (filt_sel_in == '0) ? target : acc + step;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      acc <= '0;
      result_out <= '0;
    end else begin
      acc <= next_acc;
      result_out <= next_acc[FRAC_W +: RESULT_W];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/fsr_settings.sv ----
// Trim and filter settings: power-up load, preview writes, burn sequencing
`timescale 1ns/1ps
`default_nettype none
module fsr_settings
  import fsr_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [FILT_W+GAIN_W-1:0] otp_stored_in,
  input wire logic write_valid_in,
  input wire logic [FILT_W-1:0] write_filt_in,
  input wire logic [GAIN_W-1:0] write_gain_in,
  input wire logic write_burn_in,
  input wire logic frame_start_in,
  output logic [FILT_W-1:0] filt_sel_out,
  output logic [GAIN_W-1:0] gain_trim_out,
  output logic otp_prog_out,
  output logic [FILT_W+GAIN_W-1:0] otp_prog_data_out
);
  logic loaded;
  logic burn_pending;
  logic [FILT_W+GAIN_W-1:0] burn_data;
  logic next_loaded;
  logic next_burn_pending;
  logic [FILT_W+GAIN_W-1:0] next_burn_data;
  logic [FILT_W-1:0] next_filt;
  logic [GAIN_W-1:0] next_gain;
  logic next_prog;
  logic [FILT_W+GAIN_W-1:0] next_prog_data;

  always_comb begin
    next_loaded = 1'b1;
    next_filt = filt_sel_out;
    next_gain = gain_trim_out;
    next_burn_pending = burn_pending;
    next_burn_data = burn_data;
    next_prog = 1'b0;
    next_prog_data = otp_prog_data_out;
    if (!loaded) begin
      {next_filt, next_gain} = otp_stored_in;
    end
    // Burn fires on the select fall after the arming write
    if (frame_start_in && burn_pending) begin
      next_prog = 1'b1;
      next_prog_data = burn_data;
      next_burn_pending = 1'b0;
    end
    if (write_valid_in) begin
      next_filt = write_filt_in;
      next_gain = write_gain_in;
      next_burn_pending = write_burn_in;
      next_burn_data = {write_filt_in, write_gain_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      loaded <= 1'b0;
      filt_sel_out <= '0;
      gain_trim_out <= '0;
      burn_pending <= 1'b0;
      burn_data <= '0;
      otp_prog_out <= 1'b0;
      otp_prog_data_out <= '0;
    end else begin
      loaded <= next_loaded;
      filt_sel_out <= next_filt;
      gain_trim_out <= next_gain;
      burn_pending <= next_burn_pending;
      burn_data <= next_burn_data;
      otp_prog_out <= next_prog;
      otp_prog_data_out <= next_prog_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/fsr_readout.sv ----
// Top of the flux sensor readout: serial slave, acquisition timing, result path
`timescale 1ns/1ps
`default_nettype none
module fsr_readout
  import fsr_pkg::*;
#(
  parameter int unsigned HOLD2_CYCLES = HOLD2_CYC
)(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic select_n_in,
  input wire logic sclk_in,
  input wire logic serial_in,
  input wire logic adc_valid_in,
  input wire logic [RESULT_W-1:0] adc_data_in,
  input wire logic [FILT_W+GAIN_W-1:0] otp_stored_in,
  output logic serial_out_out,
  output logic serial_out_oe_out,
  output logic hold1_out,
  output logic track2_out,
  output logic convert_start_out,
  output logic [FILT_W-1:0] filt_sel_out,
  output logic [GAIN_W-1:0] gain_trim_out,
  output logic otp_prog_out,
  output logic [FILT_W+GAIN_W-1:0] otp_prog_data_out
);
  localparam int unsigned NSYNC = 3;
  localparam int unsigned IDX_SEL = 0;
  localparam int unsigned IDX_SCK = 1;
  localparam int unsigned IDX_SDI = 2;
  localparam logic [ACQ_CNT_W-1:0] TRACK2_AT = ACQ_CNT_W'(TRACK2_CYC);
  localparam logic [ACQ_CNT_W-1:0] HOLD2_AT = ACQ_CNT_W'(HOLD2_CYCLES);
  localparam logic [ACQ_CNT_W-1:0] HOLD1_AT = ACQ_CNT_W'(HOLD1_CYC);
  // Select idles high, serial clock and input idle low
  localparam logic [NSYNC-1:0] PIN_IDLE = NSYNC'(1) << IDX_SEL;

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] pin_stable;
  logic [NSYNC-1:0] next_pin_stable;
  logic [NSYNC-1:0] pin_prev;

  assign pin_raw = {serial_in, sclk_in, select_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_comb begin
        next_pin_stable[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_stable[gi];
      end
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          // Reset to each pin's idle level so no false edge follows reset
          sync1[gi] <= PIN_IDLE[gi];
          sync2[gi] <= PIN_IDLE[gi];
          sync3[gi] <= PIN_IDLE[gi];
          pin_stable[gi] <= PIN_IDLE[gi];
          pin_prev[gi] <= PIN_IDLE[gi];
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          pin_stable[gi] <= next_pin_stable[gi];
          pin_prev[gi] <= pin_stable[gi];
        end
      end
    end
  endgenerate

  logic sel_low;
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic sdi_level;

  always_comb begin
    sel_low = ~pin_stable[IDX_SEL];
    sel_fall = pin_prev[IDX_SEL] & ~pin_stable[IDX_SEL];
    sel_rise = ~pin_prev[IDX_SEL] & pin_stable[IDX_SEL];
    // Clock edges only count inside a frame
    sck_rise = sel_low & ~pin_prev[IDX_SCK] & pin_stable[IDX_SCK];
    sck_fall = sel_low & pin_prev[IDX_SCK] & ~pin_stable[IDX_SCK];
    sdi_level = pin_stable[IDX_SDI];
  end

  // Serial frame: input shifter, output shifter, bit count
  logic [RESULT_W-1:0] result_word;
  logic [FRAME_BITS-1:0] in_shift;
  logic [RESULT_W-1:0] out_shift;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [FRAME_BITS-1:0] next_in_shift;
  logic [RESULT_W-1:0] next_out_shift;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  logic next_serial_out;
  logic next_oe;
  logic write_valid;
  logic next_write_valid;

  always_comb begin
    next_in_shift = in_shift;
    next_out_shift = out_shift;
    next_bit_cnt = bit_cnt;
    next_serial_out = serial_out_out;
    next_oe = sel_low;
    next_write_valid = 1'b0;
    if (sel_fall) begin
      // Result produced in the previous interval is presented now
      next_out_shift = result_word;
      next_serial_out = result_word[RESULT_W-1];
      next_bit_cnt = '0;
      next_in_shift = '0;
    end else begin
      if (sck_rise) begin
        next_in_shift = {in_shift[FRAME_BITS-2:0], sdi_level};
        if (bit_cnt != BIT_CNT_W'(FRAME_BITS + 1)) begin
          next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
        end
      end
      if (sck_fall) begin
        next_out_shift = {out_shift[RESULT_W-2:0], 1'b0};
        next_serial_out = out_shift[RESULT_W-2];
      end
    end
    // A frame counts as a write only with the 10 prefix and exactly sixteen bits
    if (sel_rise && bit_cnt == BIT_CNT_W'(FRAME_BITS) && in_shift[PFX_HI:PFX_LO] == WR_PREFIX) begin
      next_write_valid = 1'b1;
    end
    // Any other frame, including one starting with input low, is a plain read
    if (!sel_low) begin
      next_serial_out = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      in_shift <= '0;
      out_shift <= '0;
      bit_cnt <= '0;
      serial_out_out <= 1'b0;
      serial_out_oe_out <= 1'b0;
      write_valid <= 1'b0;
    end else begin
      in_shift <= next_in_shift;
      out_shift <= next_out_shift;
      bit_cnt <= next_bit_cnt;
      serial_out_out <= next_serial_out;
      serial_out_oe_out <= next_oe;
      write_valid <= next_write_valid;
    end
  end

  // Acquisition timing runs from the select fall alone
  fsr_acq_e acq_state;
  fsr_acq_e next_acq_state;
  logic [ACQ_CNT_W-1:0] acq_cnt;
  logic [ACQ_CNT_W-1:0] next_acq_cnt;
  logic next_hold1;
  logic next_track2;
  logic next_convert;

  always_comb begin
    next_acq_state = acq_state;
    next_acq_cnt = acq_cnt;
    next_convert = 1'b0;
    if (acq_state != FSR_ACQ_TRACK1 && acq_cnt != '1) begin
      next_acq_cnt = acq_cnt + ACQ_CNT_W'(1);
    end
    unique case (acq_state)
      FSR_ACQ_TRACK1: begin
      end
      FSR_ACQ_HOLD1: begin
        if (acq_cnt >= TRACK2_AT - HOLD1_AT) begin
          next_acq_state = FSR_ACQ_TRACK2;
        end
      end
      FSR_ACQ_TRACK2: begin
        if (acq_cnt >= HOLD2_AT - HOLD1_AT) begin
          next_acq_state = FSR_ACQ_CONV;
          next_convert = 1'b1;
        end
      end
      FSR_ACQ_CONV: begin
        if (adc_valid_in) begin
          next_acq_state = FSR_ACQ_TRACK1;
        end
      end
    endcase
    // A new select fall restarts acquisition whatever the state
    if (sel_fall) begin
      next_acq_state = FSR_ACQ_HOLD1;
      next_acq_cnt = '0;
      next_convert = 1'b0;
    end
    next_hold1 = (next_acq_state != FSR_ACQ_TRACK1);
    next_track2 = (next_acq_state == FSR_ACQ_TRACK2);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      acq_state <= FSR_ACQ_TRACK1;
      acq_cnt <= '0;
      hold1_out <= 1'b0;
      track2_out <= 1'b0;
      convert_start_out <= 1'b0;
    end else begin
      acq_state <= next_acq_state;
      acq_cnt <= next_acq_cnt;
      hold1_out <= next_hold1;
      track2_out <= next_track2;
      convert_start_out <= next_convert;
    end
  end

  // Only a conversion that was actually started is accepted
  logic conv_accept;
  always_comb begin
    conv_accept = adc_valid_in && acq_state == FSR_ACQ_CONV && !sel_fall;
  end

  fsr_settings u_settings (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .otp_stored_in(otp_stored_in),
    .write_valid_in(write_valid),
    .write_filt_in(in_shift[FILT_HI:FILT_LO]),
    .write_gain_in(in_shift[GAIN_HI:GAIN_LO]),
    .write_burn_in(in_shift[BURN_BIT]),
    .frame_start_in(sel_fall),
    .filt_sel_out(filt_sel_out),
    .gain_trim_out(gain_trim_out),
    .otp_prog_out(otp_prog_out),
    .otp_prog_data_out(otp_prog_data_out)
  );

  fsr_filter u_filter (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(conv_accept),
    .sample_in(adc_data_in),
    .filt_sel_in(filt_sel_out),
    .gain_trim_in(gain_trim_out),
    .result_out(result_word)
  );
endmodule
`default_nettype wire

// ---- test/fsr_readout_asserts.sv ----
// Port-level checks for the flux sensor readout
`timescale 1ns/1ps
`default_nettype none
module fsr_readout_chk
  import fsr_pkg::*;
#(
  parameter int unsigned HOLD2_CYCLES = HOLD2_CYC
)(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic select_n_in,
  input wire logic serial_out_out,
  input wire logic serial_out_oe_out,
  input wire logic hold1_out,
  input wire logic track2_out,
  input wire logic convert_start_out,
  input wire logic [FILT_W-1:0] filt_sel_out,
  input wire logic [GAIN_W-1:0] gain_trim_out,
  input wire logic otp_prog_out
);
  logic sel_q;
  logic next_sel_q;
  logic [15:0] since_fall;
  logic [15:0] next_since_fall;
  // Saturates so a long idle never wraps into a false window
  always_comb begin
    next_sel_q = sys_rst_in | select_n_in;
    next_since_fall = since_fall + {15'h0000, since_fall != 16'hFFFF};
    if (sys_rst_in) begin
      next_since_fall = 16'hFFFF;
    end else if (sel_q && !select_n_in) begin
      next_since_fall = 16'h0000;
    end
  end
  always_ff @(posedge clock_in) begin
    sel_q <= next_sel_q;
    since_fall <= next_since_fall;
  end
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence sel_fall;
    $fell(select_n_in);
  endsequence
  sequence sel_rise;
    $rose(select_n_in);
  endsequence
  a_drive_on_select: assert property (sel_fall |-> ##[3:7] serial_out_oe_out)
    else $error("output not driven after select fall");
  a_release_on_deselect: assert property (sel_rise |-> ##[3:7] !serial_out_oe_out)
    else $error("output still driven after select rise");
  a_idle_no_drive: assert property (select_n_in [*8] |-> !serial_out_oe_out)
    else $error("output driven while deselected");
  a_released_line_low: assert property (!serial_out_oe_out |-> !serial_out_out)
    else $error("output data not low while released");
  a_first_hold: assert property (sel_fall |-> ##[2:7] hold1_out)
    else $error("first sample not held after select fall");
  a_second_track: assert property ($rose(track2_out) |-> since_fall >= 16'h0C76 && since_fall <= 16'h0C8F)
    else $error("second sample tracking at wrong time");
  a_convert_time: assert property (convert_start_out |->
    $fell(track2_out) && since_fall + 16'h000A >= HOLD2_CYCLES && since_fall <= HOLD2_CYCLES + 16'h000A)
    else $error("conversion start at wrong time");
  a_convert_pulse: assert property (convert_start_out |=> !convert_start_out)
    else $error("conversion start longer than one cycle");
  a_burn_after_fall: assert property (otp_prog_out |-> (since_fall <= 16'h000A) ##1 !otp_prog_out)
    else $error("burn pulse misplaced or too long");
  a_settings_idle: assert property ($changed({filt_sel_out, gain_trim_out}) |-> select_n_in)
    else $error("settings changed inside a frame");
endmodule
`default_nettype wire

// ---- test/fsr_master_model.sv ----
// Behavioural serial master facing the sensor link pins
`timescale 1ns/1ps
`default_nettype none
module fsr_master_model (
  input wire logic clock_in,
  input wire logic serial_out_in,
  input wire logic serial_out_oe_in,
  output logic select_n_out,
  output logic sclk_out,
  output logic serial_in_out
);
  logic last = 1'b0;
  // Released line shows the inverse of its last bit, never a stale copy
  wire line_w = serial_out_oe_in ? serial_out_in : ~last;
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    serial_in_out = 1'b0;
  end
  always @(posedge clock_in) begin
    if (serial_out_oe_in) last <= serial_out_in;
  end
  task automatic clk_bit(input logic b, output logic s);
    @(posedge clock_in) serial_in_out <= b;
    repeat (7) @(posedge clock_in);
    sclk_out <= 1'b1;
    repeat (7) @(posedge clock_in);
    @(negedge clock_in) s = line_w;
    @(posedge clock_in) sclk_out <= 1'b0;
  endtask
  task automatic frame(input logic [15:0] bits, input int n, output logic [15:0] got);
    got = 16'h0000;
    @(posedge clock_in) select_n_out <= 1'b0;
    repeat (16) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      clk_bit(bits[15-i], got[15-i]);
    end
    repeat (8) @(posedge clock_in);
    select_n_out <= 1'b1;
  endtask
  // Link activity with select high, which the sensor must ignore
  task automatic noise(input logic [15:0] bits);
    logic s;
    for (int i = 0; i < 16; i++) begin
      clk_bit(bits[15-i], s);
    end
  endtask
endmodule
`default_nettype wire

// ---- test/fsr_readout_tb_top.sv ----
// Self-checking bench for the flux sensor readout
`timescale 1ns/1ps
`default_nettype none
module fsr_readout_tb_top;
  import fsr_pkg::*;
  // Shortened so a frame fits in about 3400 cycles
  localparam int unsigned HOLD2 = 3300;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic adc_valid_in = 1'b0;
  logic [RESULT_W-1:0] adc_data_in = 12'h000;
  logic [FILT_W+GAIN_W-1:0] otp_stored_in;
  wire select_n_in, sclk_in, serial_in, serial_out_out, serial_out_oe_out;
  wire hold1_out, track2_out, convert_start_out, otp_prog_out;
  wire [FILT_W-1:0] filt_sel_out;
  wire [GAIN_W-1:0] gain_trim_out;
  wire [FILT_W+GAIN_W-1:0] otp_prog_data_out;
  int err_total = 0;
  int n_checks = 0;
  int prog_cnt = 0;
  int acc = 0;
  logic [8:0] prog_seen = 9'h000;
  logic [FILT_W-1:0] cf;
  logic [GAIN_W-1:0] cg;
  logic [RESULT_W-1:0] exp_q = 12'h000;
  logic [15:0] last_got;
  logic [5:0] gtab [3] = '{6'h00, 6'h3F, 6'h2A};
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  fsr_readout #(.HOLD2_CYCLES(HOLD2)) DUT (.clock_in, .sys_rst_in, .select_n_in, .sclk_in, .serial_in,
    .adc_valid_in, .adc_data_in, .otp_stored_in, .serial_out_out, .serial_out_oe_out, .hold1_out,
    .track2_out, .convert_start_out, .filt_sel_out, .gain_trim_out, .otp_prog_out, .otp_prog_data_out);
  fsr_master_model master (.clock_in, .serial_out_in(serial_out_out), .serial_out_oe_in(serial_out_oe_out),
    .select_n_out(select_n_in), .sclk_out(sclk_in), .serial_in_out(serial_in));
  task automatic chk_data(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_set(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] gain_fn(input logic [11:0] x, input logic [5:0] g);
    int v;
    // Arithmetic shift rounds toward minus infinity, as the trim does
    v = 2048 + (((int'(x) - 2048) * (192 + 2 * int'(g))) >>> 8);
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    return 12'(v);
  endfunction
  // Seven fraction bits, minimum step of one so a steady input converges
  function automatic logic [11:0] filt_fn(input logic [11:0] x, input logic [2:0] c);
    int d;
    int s;
    if (c == 3'h0) begin
      acc = int'(x) <<< 7;
      return x;
    end
    d = (int'(x) <<< 7) - acc;
    s = d >>> c;
    if (s == 0 && d != 0) s = (d > 0) ? 1 : -1;
    acc = acc + s;
    return acc[18:7];
  endfunction
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input logic [15:0] cmd, input logic [RESULT_W-1:0] x);
    logic [15:0] got;
    int t;
    master.frame(cmd, (cmd[15:14] != 2'h0) ? 16 : 12, got);
    chk_data(got[15:4], exp_q);
    if (cmd[15:14] == 2'h2) begin
      cf = cmd[13:11];
      cg = cmd[10:5];
    end
    for (t = 0; t < 5000 && convert_start_out !== 1'b1; t++) begin
      @(negedge clock_in);
    end
    chk_data(12'(t == 5000), 12'h000);
    repeat (20) @(posedge clock_in);
    adc_data_in <= x;
    adc_valid_in <= 1'b1;
    @(posedge clock_in) adc_valid_in <= 1'b0;
    exp_q = filt_fn(gain_fn(x, cg), cf);
    repeat (40) @(posedge clock_in);
    chk_set({filt_sel_out, gain_trim_out}, {cf, cg});
  endtask
  always @(negedge clock_in) begin
    if (otp_prog_out === 1'b1) begin
      prog_cnt++;
      prog_seen = otp_prog_data_out;
    end
  end
  initial begin
    void'($urandom(55640));
    otp_stored_in = {3'($urandom_range(7, 1)), 6'h20};
    cf = otp_stored_in[8:6];
    cg = otp_stored_in[5:0];
    repeat (7) @(posedge clock_in);
    @(negedge clock_in) chk_set({filt_sel_out, gain_trim_out}, 9'h000);
    @(posedge clock_in) sys_rst_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    step(16'h0000, 12'($urandom_range(4095)));
    for (int c = 1; c < 8; c++) begin
      step({2'h2, 3'(c), 6'h20, 5'h00}, 12'($urandom_range(4095)));
    end
    for (int i = 0; i < 3; i++) begin
      step({2'h2, 3'h0, gtab[i], 5'h00}, (i == 0) ? 12'h800 : {5'($urandom), 7'h00});
    end
    master.noise({2'h2, 3'h5, 6'h07, 5'h01});
    repeat (10) @(posedge clock_in);
    chk_set({filt_sel_out, gain_trim_out}, {cf, cg});
    // Sixteen bits with a wrong prefix must leave the settings alone
    step(16'h5F81, 12'($urandom_range(4095)));
    step({2'h2, 3'h0, 6'h20, 5'h01}, 12'($urandom_range(4095)));
    chk_set(9'(prog_cnt), 9'h000);
    step({2'h2, 3'h0, 6'h20, 5'h00}, 12'($urandom_range(4095)));
    chk_set(prog_seen, {3'h0, 6'h20});
    chk_set(9'(prog_cnt), 9'h001);
    step(16'h0000, 12'($urandom_range(4095)));
    step(16'h0000, 12'h800);
    master.frame(16'h0000, 12, last_got);
    chk_data(last_got[15:4], exp_q);
    summarize();
  end
  initial begin
    repeat (80000) @(posedge clock_in);
    err_total++;
    summarize();
  end
endmodule
bind fsr_readout fsr_readout_chk #(.HOLD2_CYCLES(HOLD2_CYCLES)) u_chk (.clock_in, .sys_rst_in, .select_n_in,
  .serial_out_out, .serial_out_oe_out, .hold1_out, .track2_out, .convert_start_out, .filt_sel_out,
  .gain_trim_out, .otp_prog_out);
`default_nettype wire
